//--- shared/gmr_pkg.sv
// gmr_pkg: constants, reset values and carrier types of the global register bank
// assumes: one 40 MHz clock, classic wishbone register access, eight links
//
// Notes on behaviour
// - idle monitor codes route no path
// - top bit clear selects receiver of link
// - top bit set selects transmitter of link
// - first link observes the selected path
// - direction bit: zero output, one input
// - output pin drives written level bit
// - input pin level reads back, writes ignored
// - second refclk follows selected recovered clock
// - first refclk follows its own selection
// - on signal loss output master clock or high
// - summary bit n-1 shows link n pending
// - free one-second timer sets expiry flag
// - writing one clears expiry flag
// - interrupt only when enable and flag set
// - any software reset write restores defaults
package gmr_pkg;

    localparam int unsigned NUM_LINKS = 8;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_SOFT_RESET = 6'h04;
    localparam logic [5:0] IDX_PATH_MONITOR_SELECT = 6'h05;
    localparam logic [5:0] IDX_GPIO_CONTROL = 6'h06;
    localparam logic [5:0] IDX_REFCLK_OUTPUT_SELECT = 6'h07;
    localparam logic [5:0] IDX_LINK_INTERRUPT_SUMMARY = 6'h09;
    localparam logic [5:0] IDX_SECOND_TIMER_IRQ_ENABLE = 6'h0A;
    localparam logic [5:0] IDX_SECOND_TIMER_IRQ_FLAG = 6'h0B;

    // field positions
    localparam int unsigned POS_MON = 0;
    localparam int unsigned POS_DIR = 0;
    localparam int unsigned POS_LEVEL = 2;
    localparam int unsigned POS_REFA = 0;
    localparam int unsigned POS_REFB = 3;
    localparam int unsigned POS_TMR = 0;

    // reset values
    localparam logic [3:0] RST_MON = 4'h0;
    localparam logic [1:0] RST_DIR = 2'h3;
    localparam logic [1:0] RST_LEVEL = 2'h0;
    localparam logic [2:0] RST_REFSEL = 3'h0;
    localparam logic RST_TMR_EN = 1'b0;
    localparam logic RST_TMR_FLAG = 1'b0;

    // timing
    localparam int unsigned CLK_KHZ = 40000;
    localparam int unsigned TIMER_PERIOD_MS = 1000;
    localparam int unsigned TIMER_CYCLES = CLK_KHZ * TIMER_PERIOD_MS;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } gmr_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } gmr_wb_rsp_t;

    typedef struct packed {
        logic [3:0] monitor_path_select;
        logic [1:0] level;
        logic [1:0] dir;
        logic [2:0] refclk_b_link_select;
        logic [2:0] refclk_a_link_select;
        logic second_timer_irq_enable_bit;
        logic second_timer_expired_flag;
    } gmr_cfg_t;

    typedef struct packed {
        logic active;
        logic tx;
        logic [2:0] link;
    } gmr_mon_route_t;

    localparam gmr_cfg_t RST_CFG = '{
        monitor_path_select: RST_MON,
        level: RST_LEVEL,
        dir: RST_DIR,
        refclk_b_link_select: RST_REFSEL,
        refclk_a_link_select: RST_REFSEL,
        second_timer_irq_enable_bit: RST_TMR_EN,
        second_timer_expired_flag: RST_TMR_FLAG
    };

endpackage

//--- logic/gmr_second_timer.sv
// gmr_second_timer: free-running interval counter, one pulse per period
// assumes: runs from reset on mclk, never stopped by software
`timescale 1ns/1ps
`default_nettype none

module gmr_second_timer #(
    parameter int unsigned PERIOD_CYCLES = gmr_pkg::TIMER_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // one-cycle pulse at the end of each period
    output logic tick
);

    localparam int unsigned CW = $clog2(PERIOD_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(PERIOD_CYCLES - 1);

    typedef struct packed {
        logic [CW-1:0] count;
        logic tick;
    } gmr_tmr_state_t;

    gmr_tmr_state_t st_r;
    gmr_tmr_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (st_r.count == LAST) begin
            st_nxt.count = '0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.count = st_r.count + CW'(1);
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;

endmodule // gmr_second_timer

`default_nettype wire

//--- logic/gmr_global_regs.sv
// gmr_global_regs: device-wide monitor, gpio, reference clock and timer registers
// assumes: link-side inputs arrive from other clocks and are resynchronised here;
// the per-link substitute selects come from registers on mclk
`timescale 1ns/1ps
`default_nettype none

module gmr_global_regs #(
    parameter int unsigned SECOND_CYCLES = gmr_pkg::TIMER_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // wishbone slave
    input wire gmr_pkg::gmr_wb_req_t wb_req,
    output gmr_pkg::gmr_wb_rsp_t wb_rsp,
    // per-link status from the link blocks
    input wire logic [7:0] recovered_clock,
    input wire logic [7:0] link_signal_loss,
    input wire logic [7:0] link_irq_pending,
    input wire logic [7:0] ref_substitute_on_signal_loss,
    // monitoring path towards link one
    output gmr_pkg::gmr_mon_route_t monitor_route,
    output logic [7:0] monitor_rx_enable,
    output logic [7:0] monitor_tx_enable,
    // general purpose pins
    input wire logic [1:0] gpio_in,
    output logic [1:0] gpio_out,
    output logic [1:0] gpio_oe,
    // reference clock outputs
    output logic first_reference_clock_output,
    output logic second_reference_clock_output,
    // interrupt outputs
    output logic irq,
    output logic irq_n
);

    typedef struct packed {
        gmr_pkg::gmr_cfg_t cfg;
        logic ack;
        logic [31:0] rdat;
        logic [7:0] rclk_s1;
        logic [7:0] rclk_s2;
        logic [7:0] los_s1;
        logic [7:0] los_s2;
        logic [7:0] lirq_s1;
        logic [7:0] lirq_s2;
        logic [1:0] gpio_s1;
        logic [1:0] gpio_s2;
        logic refa;
        logic refb;
        logic refa_sub;
        logic refb_sub;
        gmr_pkg::gmr_mon_route_t mon;
        logic [7:0] mon_rx;
        logic [7:0] mon_tx;
        logic irq;
    } gmr_state_t;

    gmr_state_t st_r;
    gmr_state_t st_nxt;
    logic second_tick;

    // register index of a word-aligned address, or all ones when unaligned
    function automatic logic [5:0] reg_index(input logic [7:0] adr);
        logic [5:0] idx;
        idx = adr[7:2];
        if (adr[1:0] != 2'h0) begin
            idx = 6'h3F;
        end
        return idx;
    endfunction

    // decode the four-bit monitor code into a route
    function automatic gmr_pkg::gmr_mon_route_t mon_decode(input logic [3:0] code);
        gmr_pkg::gmr_mon_route_t r;
        r.tx = code[3];
        r.link = code[2:0];
        r.active = (code[2:0] != 3'h0);
        return r;
    endfunction

    // one-hot enable for the link index when the route is active
    function automatic logic [7:0] link_onehot(input logic en, input logic [2:0] link);
        logic [7:0] v;
        v = 8'h00;
        if (en) begin
            v[link] = 1'b1;
        end
        return v;
    endfunction

    gmr_second_timer #(
        .PERIOD_CYCLES(SECOND_CYCLES)
    ) u_timer (
        .mclk(mclk),
        .reset_n(reset_n),
        .tick(second_tick)
    );

    always_comb begin
        logic req;
        logic wr_now;
        logic [5:0] idx;
        logic [7:0] wb;
        logic [7:0] rd;
        logic [1:0] gpio_rd;
        gmr_pkg::gmr_cfg_t c;
        req = 1'b0;
        wr_now = 1'b0;
        idx = 6'h00;
        wb = 8'h00;
        rd = 8'h00;
        gpio_rd = 2'h0;
        c = st_r.cfg;
        st_nxt = st_r;

        // two-stage synchronisers for link-side and pin inputs
        st_nxt.rclk_s1 = recovered_clock;
        st_nxt.rclk_s2 = st_r.rclk_s1;
        st_nxt.los_s1 = link_signal_loss;
        st_nxt.los_s2 = st_r.los_s1;
        st_nxt.lirq_s1 = link_irq_pending;
        st_nxt.lirq_s2 = st_r.lirq_s1;
        st_nxt.gpio_s1 = gpio_in;
        st_nxt.gpio_s2 = st_r.gpio_s1;

        req = wb_req.cyc & wb_req.stb;
        idx = reg_index(wb_req.adr);
        wb = wb_req.dat[7:0];
        // the write lands on the edge where ack is seen high
        wr_now = req & st_r.ack & wb_req.we & wb_req.sel[0];

        // level bits read the pin for inputs, the register for outputs
        for (int i = 0; i < 2; i++) begin
            gpio_rd[i] = c.dir[i] ? st_r.gpio_s2[i] : c.level[i];
        end

        // read mux; reserved bits and unmapped words read zero
        case (idx)
            gmr_pkg::IDX_PATH_MONITOR_SELECT: begin
                rd = {4'h0, c.monitor_path_select};
            end
            gmr_pkg::IDX_GPIO_CONTROL: begin
                rd = {4'h0, gpio_rd, c.dir};
            end
            gmr_pkg::IDX_REFCLK_OUTPUT_SELECT: begin
                rd = {2'h0, c.refclk_b_link_select, c.refclk_a_link_select};
            end
            gmr_pkg::IDX_LINK_INTERRUPT_SUMMARY: begin
                rd = st_r.lirq_s2;
            end
            gmr_pkg::IDX_SECOND_TIMER_IRQ_ENABLE: begin
                rd = {7'h00, c.second_timer_irq_enable_bit};
            end
            gmr_pkg::IDX_SECOND_TIMER_IRQ_FLAG: begin
                rd = {7'h00, c.second_timer_expired_flag};
            end
            default: begin
                rd = 8'h00;
            end
        endcase

        // single-cycle classic answer: ack one cycle after the request appears
        st_nxt.ack = req & ~st_r.ack;
        if (req & ~st_r.ack) begin
            st_nxt.rdat = {24'h000000, rd};
        end

        // register writes
        if (wr_now) begin
            case (idx)
                gmr_pkg::IDX_SOFT_RESET: begin
                    c = gmr_pkg::RST_CFG;
                end
                gmr_pkg::IDX_PATH_MONITOR_SELECT: begin
                    c.monitor_path_select = wb[gmr_pkg::POS_MON +: 4];
                end
                gmr_pkg::IDX_GPIO_CONTROL: begin
                    for (int i = 0; i < 2; i++) begin
                        if (!st_r.cfg.dir[i]) begin
                            c.level[i] = wb[gmr_pkg::POS_LEVEL + i];
                        end
                    end
                    c.dir = wb[gmr_pkg::POS_DIR +: 2];
                end
                gmr_pkg::IDX_REFCLK_OUTPUT_SELECT: begin
                    c.refclk_a_link_select = wb[gmr_pkg::POS_REFA +: 3];
                    c.refclk_b_link_select = wb[gmr_pkg::POS_REFB +: 3];
                end
                gmr_pkg::IDX_SECOND_TIMER_IRQ_ENABLE: begin
                    c.second_timer_irq_enable_bit = wb[gmr_pkg::POS_TMR];
                end
                gmr_pkg::IDX_SECOND_TIMER_IRQ_FLAG: begin
                    if (wb[gmr_pkg::POS_TMR]) begin
                        c.second_timer_expired_flag = 1'b0;
                    end
                end
                default: begin
                    c = c;
                end
            endcase
        end

        // expiry wins over a clear or soft reset in the same cycle
        if (second_tick) begin
            c.second_timer_expired_flag = 1'b1;
        end
        st_nxt.cfg = c;

        // monitor routing follows the stored code
        st_nxt.mon = mon_decode(c.monitor_path_select);
        st_nxt.mon_rx = link_onehot(st_nxt.mon.active & ~st_nxt.mon.tx,
                                    st_nxt.mon.link);
        st_nxt.mon_tx = link_onehot(st_nxt.mon.active & st_nxt.mon.tx,
                                    st_nxt.mon.link);

        // reference clocks: resampled recovered clock or substitute on loss
        st_nxt.refa_sub = st_r.los_s2[c.refclk_a_link_select];
        st_nxt.refb_sub = st_r.los_s2[c.refclk_b_link_select];
        st_nxt.refa = st_nxt.refa_sub ? 1'b1 : st_r.rclk_s2[c.refclk_a_link_select];
        st_nxt.refb = st_nxt.refb_sub ? 1'b1 : st_r.rclk_s2[c.refclk_b_link_select];
        if (st_nxt.refa_sub && !ref_substitute_on_signal_loss[c.refclk_a_link_select]) begin
            st_nxt.refa = 1'b0;
        end
        if (st_nxt.refb_sub && !ref_substitute_on_signal_loss[c.refclk_b_link_select]) begin
            st_nxt.refb = 1'b0;
        end

        st_nxt.irq = c.second_timer_irq_enable_bit & c.second_timer_expired_flag;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
            st_r.cfg <= gmr_pkg::RST_CFG;
        end else begin
            st_r <= st_nxt;
        end
    end

    // substitute select: zero gives master clock, one gives a steady high
    logic refa_use_mclk;
    logic refb_use_mclk;
    assign refa_use_mclk = st_r.refa_sub
        & ~ref_substitute_on_signal_loss[st_r.cfg.refclk_a_link_select];
    assign refb_use_mclk = st_r.refb_sub
        & ~ref_substitute_on_signal_loss[st_r.cfg.refclk_b_link_select];

    assign first_reference_clock_output = refa_use_mclk ? mclk : st_r.refa;
    assign second_reference_clock_output = refb_use_mclk ? mclk : st_r.refb;

    assign wb_rsp.ack = st_r.ack;
    assign wb_rsp.dat = st_r.rdat;

    assign monitor_route = st_r.mon;
    assign monitor_rx_enable = st_r.mon_rx;
    assign monitor_tx_enable = st_r.mon_tx;

    assign gpio_out = st_r.cfg.level;
    assign gpio_oe = ~st_r.cfg.dir;

    assign irq = st_r.irq;
    assign irq_n = ~st_r.irq;

endmodule // gmr_global_regs

`default_nettype wire

//--- testbench/gmr_global_regs_sva.sv
// gmr_global_regs_sva: port assertions for the global register bank
// assumes: bound to gmr_global_regs; single mclk domain
`timescale 1ns/1ps
`default_nettype none

module gmr_global_regs_sva (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // register bus
    input wire gmr_pkg::gmr_wb_req_t wb_req,
    input wire gmr_pkg::gmr_wb_rsp_t wb_rsp,
    // watched outputs
    input wire gmr_pkg::gmr_mon_route_t monitor_route,
    input wire logic [7:0] monitor_rx_enable,
    input wire logic [7:0] monitor_tx_enable,
    input wire logic [1:0] gpio_out,
    input wire logic [1:0] gpio_oe,
    input wire logic irq,
    input wire logic irq_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    logic wr;
    logic [7:0] wd_r;
    assign wr = wb_rsp.ack && wb_req.we && wb_req.sel[0];
    // write data as it stood at the ack edge
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) wd_r <= 8'h00;
        else wd_r <= wb_req.dat[7:0];
    end
    property p_ack_once;
        wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack ##1 !wb_rsp.ack;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack not a single pulse");
    property p_idle;
        !monitor_route.active |-> monitor_rx_enable == 8'h00 && monitor_tx_enable == 8'h00;
    endproperty
    a_idle: assert property (p_idle) else $error("idle route enables a path");
    property p_rx;
        monitor_route.active && !monitor_route.tx |->
            monitor_rx_enable == 8'h01 << monitor_route.link && monitor_tx_enable == 8'h00;
    endproperty
    a_rx: assert property (p_rx) else $error("receiver enable wrong");
    property p_tx;
        monitor_route.active && monitor_route.tx |->
            monitor_tx_enable == 8'h01 << monitor_route.link && monitor_rx_enable == 8'h00;
    endproperty
    a_tx: assert property (p_tx) else $error("transmitter enable wrong");
    property p_mon_sel;
        wr && wb_req.adr == 8'h14 |=> monitor_route.link == wd_r[2:0] &&
            monitor_route.tx == wd_r[3] && monitor_route.active == (wd_r[2:0] != 3'h0);
    endproperty
    a_mon_sel: assert property (p_mon_sel) else $error("route not updated");
    property p_gpio_dir;
        wr && wb_req.adr == 8'h18 |=> gpio_oe == ~wd_r[1:0];
    endproperty
    a_gpio_dir: assert property (p_gpio_dir) else $error("gpio enable wrong");
    property p_gpio_lvl;
        wr && wb_req.adr == 8'h18 && gpio_oe == 2'b11 |=> gpio_out == wd_r[3:2];
    endproperty
    a_gpio_lvl: assert property (p_gpio_lvl) else $error("gpio level wrong");
    property p_rsv;
        wb_rsp.ack && !wb_req.we |-> wb_rsp.dat[31:8] == 24'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("upper read bits set");
    property p_irq_off;
        wr && wb_req.adr == 8'h28 && !wb_req.dat[0] |=> !irq && irq_n;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
    property p_irq_hold;
        irq && !(wr && (wb_req.adr == 8'h28 || wb_req.adr == 8'h2C || wb_req.adr == 8'h10))
            |=> irq;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped alone");
    property p_irq_n;
        irq_n != irq;
    endproperty
    a_irq_n: assert property (p_irq_n) else $error("irq_n not inverse");
endmodule // gmr_global_regs_sva

bind gmr_global_regs gmr_global_regs_sva i_sva (
    .mclk(mclk), .reset_n(reset_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .monitor_route(monitor_route), .monitor_rx_enable(monitor_rx_enable),
    .monitor_tx_enable(monitor_tx_enable), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .irq(irq), .irq_n(irq_n)
);
`default_nettype wire

//--- testbench/tb.sv
// tb: self-checking bench for the global register bank
// assumes: short second period, classic wishbone reads and writes
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    gmr_pkg::gmr_wb_req_t wb_req = '0;
    gmr_pkg::gmr_wb_rsp_t wb_rsp;
    logic [7:0] rclk = 8'h00;
    logic [7:0] los = 8'h00;
    logic [7:0] pend = 8'h00;
    logic [7:0] subst = 8'h00;
    logic [1:0] gpio_in = 2'b10;
    gmr_pkg::gmr_mon_route_t route;
    logic [7:0] rx_en, tx_en, rd, m;
    logic [1:0] gpio_out, gpio_oe;
    logic ref_a, ref_b, irq, irq_n;
    int err_count = 0;
    int compares = 0;
    int cyc_cnt = 0;

    always #12.5 mclk = ~mclk;

    gmr_global_regs #(.SECOND_CYCLES(50)) i_dut (
        .mclk(mclk), .reset_n(reset_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
        .recovered_clock(rclk), .link_signal_loss(los), .link_irq_pending(pend),
        .ref_substitute_on_signal_loss(subst), .monitor_route(route),
        .monitor_rx_enable(rx_en), .monitor_tx_enable(tx_en), .gpio_in(gpio_in),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .first_reference_clock_output(ref_a),
        .second_reference_clock_output(ref_b), .irq(irq), .irq_n(irq_n)
    );

    task automatic give_verdict;
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one classic cycle; returns at the ack edge
    task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] d);
        @(posedge mclk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: {24'h0, d}};
        do @(posedge mclk); while (wb_rsp.ack !== 1'b1);
        rd = wb_rsp.dat[7:0];
        wb_req <= '0;
    endtask

    task automatic rdc(input logic [7:0] adr, input logic [7:0] exp);
        bus(1'b0, adr, 8'h00);
        chk(rd, exp);
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask

    always @(posedge mclk) begin
        cyc_cnt++;
        if (cyc_cnt == 3000) begin
            err_count++;
            give_verdict();
        end
    end

    initial begin
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        rdc(8'h2C, 8'h00);
        rdc(8'h18, 8'h0B);
        rdc(8'h1C, 8'h00);
        rdc(8'h3C, 8'h00);
        rdc(8'h15, 8'h00);
        for (int c = 0; c < 16; c++) begin
            bus(1'b1, 8'h14, 8'(c));
            wt(0);
            m = (c[2:0] == 3'h0) ? 8'h00 : 8'h01 << c[2:0];
            chk(rx_en, c[3] ? 8'h00 : m);
            chk(tx_en, c[3] ? m : 8'h00);
            rdc(8'h14, 8'(c));
        end
        bus(1'b1, 8'h14, 8'hF5);
        rdc(8'h14, 8'h05);
        bus(1'b1, 8'h18, 8'h00);
        bus(1'b1, 8'h18, 8'h04);
        wt(0);
        chk({4'h0, gpio_oe, gpio_out}, 8'h0D);
        rdc(8'h18, 8'h04);
        bus(1'b1, 8'h18, 8'h0E);
        rdc(8'h18, 8'h0E);
        @(posedge mclk);
        gpio_in <= 2'b00;
        wt(4);
        rdc(8'h18, 8'h06);
        bus(1'b1, 8'h18, 8'h0A);
        rdc(8'h18, 8'h02);
        bus(1'b1, 8'h1C, 8'hEA);
        rdc(8'h1C, 8'h2A);
        @(posedge mclk);
        rclk <= 8'h04;
        wt(6);
        chk({6'h0, ref_b, ref_a}, 8'h01);
        @(posedge mclk);
        rclk <= 8'h20;
        wt(6);
        chk({6'h0, ref_b, ref_a}, 8'h02);
        @(posedge mclk);
        rclk <= 8'h00;
        los <= 8'h20;
        subst <= 8'h20;
        wt(6);
        chk({6'h0, ref_b, ref_a}, 8'h02);
        @(posedge mclk);
        subst <= 8'h00;
        wt(6);
        chk({6'h0, ref_b, ref_a}, 8'h02);
        #12.5;
        chk({6'h0, ref_b, ref_a}, 8'h00);
        @(posedge mclk);
        pend <= 8'hA5;
        wt(4);
        rdc(8'h24, 8'hA5);
        bus(1'b1, 8'h24, 8'h00);
        rdc(8'h24, 8'hA5);
        rd = 8'h00;
        while (rd[0] !== 1'b1) bus(1'b0, 8'h2C, 8'h00);
        chk({7'h0, irq}, 8'h00);
        bus(1'b1, 8'h2C, 8'h00);
        rdc(8'h2C, 8'h01);
        bus(1'b1, 8'h28, 8'h01);
        wt(1);
        chk({7'h0, irq}, 8'h01);
        bus(1'b1, 8'h28, 8'h00);
        wt(1);
        chk({7'h0, irq}, 8'h00);
        // wait for a fresh expiry so that the next one is a whole period away
        bus(1'b1, 8'h2C, 8'h01);
        rd = 8'h00;
        while (rd[0] !== 1'b1) bus(1'b0, 8'h2C, 8'h00);
        bus(1'b1, 8'h2C, 8'h01);
        rdc(8'h2C, 8'h00);
        bus(1'b1, 8'h28, 8'h01);
        bus(1'b1, 8'h14, 8'h09);
        bus(1'b1, 8'h10, 8'h5A);
        rdc(8'h14, 8'h00);
        rdc(8'h18, 8'h03);
        rdc(8'h1C, 8'h00);
        rdc(8'h28, 8'h00);
        give_verdict();
    end
endmodule // tb
`default_nettype wire
